/* File: sms_clkgen.sv */
module sms_clkgen (
  input wire logic clock,
  input wire logic reset,
  input wire logic run,
  input wire logic [2:0] mode,
  input wire logic tmr_match,
  sms_pin_if.gen_mp pins
);
  import sms_pkg::*;

  typedef struct packed {
    logic [5:0] cnt;
    logic sub_prev;
    logic tick;
  } sms_gen_s;

  sms_gen_s s_q;
  sms_gen_s s_d;
  logic [5:0] half;

  // one tick per half serial period; while run is low the counter is held at zero and no tick is sent
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    s_d.sub_prev = pins.sub_s;
    half = SMS_HALF_DIV4;
    case (mode)
      SMS_MODE_DIV16: half = SMS_HALF_DIV16;
      SMS_MODE_DIV64: half = SMS_HALF_DIV64;
      default: half = SMS_HALF_DIV4;
    endcase
    if (!run) begin
      s_d.cnt = '0;
    end else if (mode == SMS_MODE_SUB) begin
      s_d.tick = pins.sub_s ^ s_q.sub_prev;
    end else if (mode == SMS_MODE_TMR) begin
      s_d.tick = tmr_match;
    end else if (s_q.cnt == half - 6'h01) begin
      s_d.cnt = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 6'h01;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pins.tick = s_q.tick;
endmodule

/* File: sms_peer.sv */
module sms_peer (
  input wire logic clock,
  input wire logic loop,
  input wire logic sdo_m,
  output logic sclk_s,
  output logic ss_n_s,
  output logic sdi_s
);
  timeunit 1ns;
  timeprecision 1ps;
  // system clocks per half serial period, well above the input synchroniser delay
  localparam int HALF = 8;
  logic sdi_q;

  // master runs: the far slave echoes our output inverted, so a received word differs from the sent one
  assign sdi_s = loop ? ~sdo_m : sdi_q;

  // clock rests at the pol0 idle level outside frames, select released
  initial begin
    sclk_s = 1'b1;
    ss_n_s = 1'b1;
    sdi_q = 1'b1;
  end

  // external master frame; nbits below 8 aborts the frame early
  // cap1: the port captures on leading edges, so each bit is set up a half period ahead of them
  task automatic xfer(input logic [7:0] tx, input logic msb, input logic sel, input logic cap1, input int nbits,
                      output logic [7:0] rx);
    int k;
    rx = 8'h00;
    @(posedge clock);
    ss_n_s <= ~sel;
    if (cap1) begin
      sdi_q <= msb ? tx[7] : tx[0];
    end
    repeat (HALF) @(posedge clock);
    for (k = 0; k < nbits; k++) begin
      if (cap1) begin
        rx = msb ? {rx[6:0], sdo_m} : {sdo_m, rx[7:1]};
      end else begin
        sdi_q <= msb ? tx[7-k] : tx[k];
      end
      sclk_s <= 1'b0;
      repeat (HALF) @(posedge clock);
      if (!cap1) begin
        rx = msb ? {rx[6:0], sdo_m} : {sdo_m, rx[7:1]};
      end else if (k < 7) begin
        sdi_q <= msb ? tx[6-k] : tx[k+1];
      end
      sclk_s <= 1'b1;
      repeat (HALF) @(posedge clock);
    end
    ss_n_s <= 1'b1;
    // released line: show the inverse so a stale value is never mistaken for data
    sdi_q <= ~sdi_q;
  endtask
endmodule

/* File: sms_pin_if.sv */
interface sms_pin_if;
  logic sclk_s;
  logic sdi_s;
  logic ss_n_s;
  logic sub_s;
  logic tick;
  modport sync_mp (output sclk_s, output sdi_s, output ss_n_s, output sub_s);
  modport gen_mp (input sub_s, output tick);
  modport core_mp (input sclk_s, input sdi_s, input ss_n_s, input tick);
endinterface

/* File: sms_pkg.sv */
package sms_pkg;

  // apb map, byte addresses of 32-bit words
  localparam int unsigned SMS_ADDR_W = 8;
  localparam logic [7:0] SMS_ADDR_MODE = 8'h00;
  localparam logic [7:0] SMS_ADDR_FMT = 8'h04;
  localparam logic [7:0] SMS_ADDR_DATA = 8'h08;

  // serial_mode_control fields
  localparam int unsigned SMS_MC_MODE_LSB = 5;
  localparam int unsigned SMS_MC_DEB_LSB = 2;
  localparam int unsigned SMS_MC_EN_BIT = 1;
  localparam int unsigned SMS_MC_ICF_BIT = 0;
  localparam logic [7:0] SMS_MODE_CTRL_RST = 8'hE0;

  // spi_format_control fields
  localparam int unsigned SMS_FMT_HI_LSB = 6;
  localparam int unsigned SMS_FMT_POL_BIT = 5;
  localparam int unsigned SMS_FMT_EDGE_BIT = 4;
  localparam int unsigned SMS_FMT_ORDER_BIT = 3;
  localparam int unsigned SMS_FMT_SEL_BIT = 2;
  localparam int unsigned SMS_FMT_WRITE_COLLISION_FLAG_BIT = 1;
  localparam int unsigned SMS_FMT_TRF_BIT = 0;
  localparam logic [7:0] SMS_FMT_RST = 8'h00;
  localparam logic [7:0] SMS_DATA_RST = 8'h00;

  // interface_mode_field codes
  localparam logic [2:0] SMS_MODE_DIV4 = 3'h0;
  localparam logic [2:0] SMS_MODE_DIV16 = 3'h1;
  localparam logic [2:0] SMS_MODE_DIV64 = 3'h2;
  localparam logic [2:0] SMS_MODE_SUB = 3'h3;
  localparam logic [2:0] SMS_MODE_TMR = 3'h4;
  localparam logic [2:0] SMS_MODE_SLAVE = 3'h5;

  // system clocks per half serial clock period
  localparam logic [5:0] SMS_HALF_DIV4 = 6'h02;
  localparam logic [5:0] SMS_HALF_DIV16 = 6'h08;
  localparam logic [5:0] SMS_HALF_DIV64 = 6'h20;

  // sixteen clock edges carry one eight-bit word
  localparam logic [3:0] SMS_LAST_EDGE = 4'hF;

  typedef enum logic [1:0] {
    SMS_IDLE = 2'b01,
    SMS_SHIFT = 2'b10
  } sms_state_e;

endpackage

/* File: sms_sync.sv */
module sms_sync (
  input wire logic clock,
  input wire logic reset,
  input wire logic [3:0] raw,
  sms_pin_if.sync_mp pins
);
  typedef struct packed {
    logic [3:0] meta;
    logic [3:0] sync;
  } sms_sync_s;

  sms_sync_s s_q;
  sms_sync_s s_d;

  // first stage feeds only the second stage
  always_comb begin
    s_d = s_q;
    s_d.meta = raw;
    s_d.sync = s_q.meta;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // order: sclk, sdi, ss_n, sub clock
  assign pins.sclk_s = s_q.sync[0];
  assign pins.sdi_s = s_q.sync[1];
  assign pins.ss_n_s = s_q.sync[2];
  assign pins.sub_s = s_q.sync[3];
endmodule

/* File: sms_top.sv */
// Decided for this implementation: the placing of the registers and the APB slave port.
module sms_top (
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sms_pkg::SMS_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sclk_in,
  input wire logic sdi_in,
  input wire logic ss_n_in,
  input wire logic sub_clk_in,
  input wire logic tmr_match,
  output logic sclk_out,
  output logic sclk_oe,
  output logic sdo_out,
  output logic sdo_oe,
  output logic ss_n_out,
  output logic ss_n_oe,
  output logic pins_spi_sel
);
  import sms_pkg::*;

  typedef struct packed {
    logic [2:0] mode;
    logic [1:0] deb;
    logic en;
    logic icf;
    logic [1:0] fmt_hi;
    logic pol;
    logic edge_sel;
    logic order;
    logic sel_en;
    logic write_collision_flag;
    logic transfer_complete_flag;
    logic [7:0] data;
    logic [7:0] tx;
    logic [7:0] rx;
    logic [3:0] edge_cnt;
    sms_state_e st;
    logic sck_lvl;
    logic sclk_prev;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic sclk_out;
    logic sclk_oe;
    logic sdo_out;
    logic sdo_oe;
    logic ss_n_out;
    logic ss_n_oe;
    logic pin_sel;
  } sms_top_s;

  sms_top_s s_q;
  sms_top_s s_d;
  sms_pin_if pins ();

  logic active;
  logic master;
  logic slave;
  logic selected;
  logic busy;
  logic ev;
  logic lead;
  logic capture;
  logic acc;
  logic commit;
  logic wr_data;
  logic set_trf;
  logic set_icf;
  logic set_write_collision_flag;
  logic [7:0] rx_next;

  sms_sync u_sync (
    .clock(clock),
    .reset(reset),
    .raw({sub_clk_in, ss_n_in, sdi_in, sclk_in}),
    .pins(pins.sync_mp)
  );

  sms_clkgen u_gen (
    .clock(clock),
    .reset(reset),
    .run(master && busy),
    .mode(s_q.mode),
    .tmr_match(tmr_match),
    .pins(pins.gen_mp)
  );

  // mode decode; codes 110 and 111 leave the port idle
  always_comb begin
    active = s_q.en && (s_q.mode <= SMS_MODE_SLAVE);
    master = active && (s_q.mode != SMS_MODE_SLAVE);
    slave = active && (s_q.mode == SMS_MODE_SLAVE);
    selected = !s_q.sel_en || !pins.ss_n_s;
    busy = (s_q.st == SMS_SHIFT);
    acc = psel && penable && !s_q.pready;
    commit = psel && penable && s_q.pready && pwrite;
    wr_data = commit && (paddr == SMS_ADDR_DATA);
  end

  // one serial clock edge: master tick or slave line change while selected
  always_comb begin
    ev = 1'b0;
    if (master && busy) begin
      ev = pins.tick;
    end else if (slave && selected) begin
      ev = pins.sclk_s != s_q.sclk_prev;
    end
    lead = !s_q.edge_cnt[0];
    capture = (lead == s_q.edge_sel);
    if (s_q.order) begin
      rx_next = {s_q.rx[6:0], pins.sdi_s};
    end else begin
      rx_next = {pins.sdi_s, s_q.rx[7:1]};
    end
  end

  // whole next-state: apb answer, shift engine, register writes, flag sets
  always_comb begin
    s_d = s_q;
    set_trf = 1'b0;
    set_icf = 1'b0;
    set_write_collision_flag = 1'b0;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    s_d.sclk_prev = pins.sclk_s;

    // answer one cycle into the access phase, read data latched with it
    if (acc) begin
      s_d.pready = 1'b1;
      s_d.prdata = '0;
      case (paddr)
        SMS_ADDR_MODE: s_d.prdata[7:0] = {s_q.mode, 1'b0, s_q.deb, s_q.en, s_q.icf};
        SMS_ADDR_FMT: s_d.prdata[7:0] = {s_q.fmt_hi, s_q.pol, s_q.edge_sel, s_q.order,
                                          s_q.sel_en, s_q.write_collision_flag, s_q.transfer_complete_flag};
        SMS_ADDR_DATA: s_d.prdata[7:0] = s_q.data;
        default: s_d.pslverr = 1'b1;
      endcase
    end

    // shift engine
    if (!active) begin
      s_d.st = SMS_IDLE;
      s_d.edge_cnt = '0;
    end else if (slave && s_q.sel_en && pins.ss_n_s && busy) begin
      // master let go mid-word: abandon it and flag it
      s_d.st = SMS_IDLE;
      s_d.edge_cnt = '0;
      set_icf = 1'b1;
      set_trf = 1'b1;
    end else if (ev) begin
      s_d.st = SMS_SHIFT;
      if (capture) begin
        s_d.rx = rx_next;
      end else if (s_q.edge_cnt != 4'h0) begin
        // first leading edge must not advance: the first bit (tx[7] msb first, tx[0] lsb first) is already on the line
        if (s_q.order) begin
          s_d.tx = {s_q.tx[6:0], 1'b0};
        end else begin
          s_d.tx = {1'b0, s_q.tx[7:1]};
        end
      end
      if (s_q.edge_cnt == SMS_LAST_EDGE) begin
        s_d.st = SMS_IDLE;
        s_d.edge_cnt = '0;
        s_d.data = capture ? rx_next : s_q.rx;
        set_trf = 1'b1;
      end else begin
        s_d.edge_cnt = s_q.edge_cnt + 4'h1;
      end
    end

    // serial clock level: toggles per tick, otherwise parked at idle level
    if (master && busy) begin
      if (pins.tick) begin
        s_d.sck_lvl = !s_q.sck_lvl;
      end
    end else begin
      s_d.sck_lvl = !s_q.pol;
    end

    // register writes take effect on the completing edge only
    if (commit && (paddr == SMS_ADDR_MODE)) begin
      s_d.mode = pwdata[SMS_MC_MODE_LSB +: 3];
      s_d.deb = pwdata[SMS_MC_DEB_LSB +: 2];
      s_d.en = pwdata[SMS_MC_EN_BIT];
      s_d.icf = pwdata[SMS_MC_ICF_BIT]; // software set does not raise trf
    end
    if (commit && (paddr == SMS_ADDR_FMT)) begin
      s_d.fmt_hi = pwdata[SMS_FMT_HI_LSB +: 2];
      s_d.pol = pwdata[SMS_FMT_POL_BIT];
      s_d.edge_sel = pwdata[SMS_FMT_EDGE_BIT];
      s_d.order = pwdata[SMS_FMT_ORDER_BIT];
      s_d.sel_en = pwdata[SMS_FMT_SEL_BIT];
      s_d.write_collision_flag = pwdata[SMS_FMT_WRITE_COLLISION_FLAG_BIT];
      s_d.transfer_complete_flag = pwdata[SMS_FMT_TRF_BIT];
    end
    if (wr_data) begin
      if (busy) begin
        set_write_collision_flag = 1'b1;
      end else begin
        s_d.data = pwdata[7:0];
        s_d.tx = pwdata[7:0];
        if (master) begin
          s_d.st = SMS_SHIFT;
          s_d.edge_cnt = '0;
        end
      end
    end

    // hardware sets win over a software clear in the same cycle
    s_d.transfer_complete_flag = s_d.transfer_complete_flag | set_trf;
    s_d.icf = s_d.icf | set_icf;
    s_d.write_collision_flag = s_d.write_collision_flag | set_write_collision_flag;

    // pin drive, all registered
    s_d.pin_sel = active;
    s_d.sclk_oe = master;
    s_d.sclk_out = s_d.sck_lvl;
    s_d.sdo_oe = active;
    if ((master && s_d.st == SMS_SHIFT) || (slave && selected)) begin
      s_d.sdo_out = s_d.order ? s_d.tx[7] : s_d.tx[0];
    end else begin
      s_d.sdo_out = 1'b1;
    end
    s_d.ss_n_oe = master && s_q.sel_en;
    s_d.ss_n_out = (s_d.st != SMS_SHIFT);
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s_q <= '0;
      s_q.mode <= SMS_MODE_CTRL_RST[SMS_MC_MODE_LSB +: 3];
      s_q.st <= SMS_IDLE;
      s_q.sck_lvl <= 1'b1;
      s_q.sclk_out <= 1'b1;
      s_q.sdo_out <= 1'b1;
      s_q.ss_n_out <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign sclk_out = s_q.sclk_out;
  assign sclk_oe = s_q.sclk_oe;
  assign sdo_out = s_q.sdo_out;
  assign sdo_oe = s_q.sdo_oe;
  assign ss_n_out = s_q.ss_n_out;
  assign ss_n_oe = s_q.ss_n_oe;
  assign pins_spi_sel = s_q.pin_sel;

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  a_sclk_idle_level: assert property ((s_q.st == SMS_IDLE) && $past(s_q.st == SMS_IDLE) && s_q.sclk_oe
    && $past(s_q.sclk_oe) && $stable(s_q.pol) |-> s_q.sclk_out == !s_q.pol)
    else $error("master clock not at idle level");
  a_write_collision_flag_busy_write: assert property (wr_data && busy |=> s_q.write_collision_flag && ($past(ev) || $stable(s_q.tx)))
    else $error("collision write not flagged or not dropped");
  a_trf_word_done: assert property (ev && (s_q.edge_cnt == SMS_LAST_EDGE) && busy
    |=> s_q.transfer_complete_flag && (s_q.st == SMS_IDLE))
    else $error("complete flag missing after eighth bit");
  // sub clock and timer sources have no bounded rate, so only the divider modes are timed
  a_master_write_start: assert property (wr_data && !busy && master && (s_q.mode <= SMS_MODE_DIV64)
    |=> s_q.st == SMS_SHIFT ##[1:130] s_q.sclk_out == s_q.pol)
    else $error("master write did not start clocking");
  a_data_hold_shift: assert property ((s_q.st == SMS_SHIFT) && $past(s_q.st == SMS_SHIFT)
    |-> $stable(s_q.data))
    else $error("data register changed mid-word");
  a_slave_abort_flag: assert property (slave && s_q.sel_en && pins.ss_n_s && busy
    |=> s_q.icf && s_q.transfer_complete_flag && (s_q.st == SMS_IDLE))
    else $error("incomplete transfer not flagged");
  a_pins_released: assert property (!s_q.en |=> !sclk_oe && !sdo_oe && !ss_n_oe && !pins_spi_sel)
    else $error("pins not released while disabled");
  a_fmt_hi_store: assert property (commit && (paddr == SMS_ADDR_FMT)
    |=> s_q.fmt_hi == $past(pwdata[7:6]))
    else $error("spare format bits not stored");
  a_select_float: assert property (!s_q.sel_en |=> !ss_n_oe)
    else $error("select pin driven while disabled");

  c_master_word: cover property (master && busy ##1 (s_q.st == SMS_IDLE) && s_q.transfer_complete_flag);
  c_slave_abort: cover property (slave && s_q.sel_en && pins.ss_n_s && busy);
  c_collision: cover property (wr_data && busy);
endmodule

/* File: tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sms_pkg::*;
  logic clock, reset, psel, penable, pwrite, loop, er;
  logic [7:0] paddr, rd, prx;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, sclk_in, sdi_in, ss_n_in, sclk_out, sclk_oe, sdo_out, sdo_oe;
  logic ss_n_out, ss_n_oe, pins_spi_sel;
  int n_fail, tests_run, n_tog, t0;
  logic sub_clk, tmr_pulse;
  logic [3:0] src_cnt;

  // sub clock and timer match come from the free-running source below
  sms_top i_dut (.clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sclk_in(sclk_in), .sdi_in(sdi_in), .ss_n_in(ss_n_in), .sub_clk_in(sub_clk), .tmr_match(tmr_pulse),
    .sclk_out(sclk_out), .sclk_oe(sclk_oe), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .ss_n_out(ss_n_out),
    .ss_n_oe(ss_n_oe), .pins_spi_sel(pins_spi_sel));
  sms_peer i_peer (.clock(clock), .loop(loop), .sdo_m(sdo_out), .sclk_s(sclk_in), .ss_n_s(ss_n_in),
    .sdi_s(sdi_in));

  // 100 MHz system clock
  initial clock = 1'b0;
  always #5 clock = ~clock;

  // timer match pulse and sub clock edge every 8 cycles, same pace as the divide-by-16 source
  always @(posedge clock) begin
    src_cnt <= src_cnt + 4'h1;
    tmr_pulse <= (src_cnt[2:0] == 3'h7);
    sub_clk <= src_cnt[3];
  end

  // every serial clock edge driven out, compared as a difference only
  always @(sclk_out) n_tog++;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // apb transfer; request held until the rising edge that samples pready high, data taken there
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r,
                     output logic e);
    int n = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) begin
      n_fail++;
      $display("[FAIL] %0t apb ready never came", $time);
    end
    r = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d, rd, er);
    repeat (4) @(negedge clock);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00, rd, er);
    chk(rd, exp);
  endtask

  // poll the format register until the complete flag shows, bounded
  task automatic wait_trf;
    for (int i = 0; i < 200; i++) begin
      apb(1'b0, SMS_ADDR_FMT, 8'h00, rd, er);
      if (rd[0] === 1'b1) break;
    end
    if (rd[0] !== 1'b1) begin
      n_fail++;
      $display("[FAIL] %0t complete flag never set", $time);
    end
  endtask

  task automatic t_regs;
    rchk(SMS_ADDR_MODE, 8'hE0);
    rchk(SMS_ADDR_FMT, 8'h00);
    rchk(SMS_ADDR_DATA, 8'h00);
    chk(pins_spi_sel, 8'h00);
    apb(1'b1, 8'h0C, 8'hFF, rd, er);
    chk(er, 8'h01);
    rchk(8'h0C, 8'h00);
    wr(SMS_ADDR_FMT, 8'hC0);
    rchk(SMS_ADDR_FMT, 8'hC0);
    for (int c = 0; c < 6; c++) begin
      wr(SMS_ADDR_MODE, {3'(c), 5'h00});
      rchk(SMS_ADDR_MODE, {3'(c), 5'h00});
    end
  endtask

  task automatic t_master;
    loop = 1'b1;
    wr(SMS_ADDR_MODE, 8'h22);
    wr(SMS_ADDR_FMT, 8'h0C);
    chk(sclk_out, 8'h01);
    chk({sclk_oe, sdo_out, sdo_oe, ss_n_oe, pins_spi_sel}, 8'h1F);
    t0 = n_tog;
    wr(SMS_ADDR_DATA, 8'hA5);
    wr(SMS_ADDR_DATA, 8'h33);
    wait_trf();
    chk(8'(n_tog - t0), 8'h10);
    chk(sclk_out, 8'h01);
    rchk(SMS_ADDR_FMT, 8'h0F);
    rchk(SMS_ADDR_DATA, 8'h5A);
    wr(SMS_ADDR_FMT, 8'h0C);
    rchk(SMS_ADDR_FMT, 8'h0C);
    wr(SMS_ADDR_FMT, 8'h28);
    chk(sclk_out, 8'h00);
    chk(ss_n_oe, 8'h00);
  endtask

  // timer, sub clock and divide-by-64 sources with polarity 1; echo comes back inverted
  task automatic t_sources;
    logic [2:0] m;
    loop = 1'b1;
    for (int i = 0; i < 3; i++) begin
      m = (i == 0) ? SMS_MODE_TMR : ((i == 1) ? SMS_MODE_SUB : SMS_MODE_DIV64);
      wr(SMS_ADDR_MODE, {m, 5'h02});
      wr(SMS_ADDR_FMT, 8'h2C);
      chk(sclk_out, 8'h00);
      t0 = n_tog;
      wr(SMS_ADDR_DATA, 8'h69);
      wait_trf();
      chk(8'(n_tog - t0), 8'h10);
      chk(sclk_out, 8'h00);
      rchk(SMS_ADDR_DATA, 8'h96);
    end
  endtask

  task automatic t_slave;
    loop = 1'b0;
    wr(SMS_ADDR_MODE, 8'hA2);
    wr(SMS_ADDR_FMT, 8'h0C);
    chk(sclk_oe, 8'h00);
    wr(SMS_ADDR_DATA, 8'h3C);
    i_peer.xfer(8'h96, 1'b1, 1'b1, 1'b0, 8, prx);
    chk(prx, 8'h3C);
    rchk(SMS_ADDR_DATA, 8'h96);
    rchk(SMS_ADDR_FMT, 8'h0D);
    // lsb first with the select pin switched off: select line stays high
    wr(SMS_ADDR_FMT, 8'h00);
    wr(SMS_ADDR_DATA, 8'hC5);
    i_peer.xfer(8'h1E, 1'b0, 1'b0, 1'b0, 8, prx);
    chk(prx, 8'hC5);
    rchk(SMS_ADDR_DATA, 8'h1E);
    rchk(SMS_ADDR_FMT, 8'h01);
    // edge select 1: capture on the leading edge, shift on the trailing one
    wr(SMS_ADDR_FMT, 8'h1C);
    wr(SMS_ADDR_DATA, 8'h81);
    i_peer.xfer(8'h42, 1'b1, 1'b1, 1'b1, 8, prx);
    chk(prx, 8'h81);
    rchk(SMS_ADDR_DATA, 8'h42);
  endtask

  task automatic t_abort;
    wr(SMS_ADDR_FMT, 8'h0C);
    i_peer.xfer(8'hFF, 1'b1, 1'b1, 1'b0, 3, prx);
    repeat (6) @(posedge clock);
    rchk(SMS_ADDR_MODE, 8'hA3);
    rchk(SMS_ADDR_FMT, 8'h0D);
    wr(SMS_ADDR_MODE, 8'hA0);
    chk({pins_spi_sel, sdo_oe, sclk_oe, ss_n_oe}, 8'h00);
  endtask

  task automatic report_and_stop;
    if (n_fail == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // main sequence: 8-cycle reset, then the scenarios in turn
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    loop = 1'b0;
    n_fail = 0;
    tests_run = 0;
    n_tog = 0;
    src_cnt = 4'h0;
    tmr_pulse = 1'b0;
    sub_clk = 1'b0;
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    t_regs();
    t_master();
    t_sources();
    t_slave();
    t_abort();
    report_and_stop();
  end

  // watchdog: the scenarios need a few thousand cycles at most
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    $display("[FAIL] %0t watchdog expired", $time);
    report_and_stop();
  end
endmodule
